// ### shared/pmlp_pkg.sv
package pmlp_pkg;

    // register offsets on the serial control port
    localparam logic [14:0] PMLP_ADDR_TRIM_A = 15'h0037;
    localparam logic [14:0] PMLP_ADDR_CAL_EN = 15'h0061;
    localparam logic [14:0] PMLP_ADDR_CAL_MODE = 15'h0062;
    localparam logic [14:0] PMLP_ADDR_SOFT_TRIG = 15'h006C;
    localparam logic [14:0] PMLP_ADDR_LOWPOWER_SWAP_TRIGGER_CONTROL = 15'h006D;
    localparam logic [14:0] PMLP_ADDR_LINK_EN = 15'h0200;
    localparam logic [14:0] PMLP_ADDR_LINK_MODE = 15'h0201;
    localparam logic [14:0] PMLP_ADDR_FRAME_CNT = 15'h0202;
    localparam logic [14:0] PMLP_ADDR_SCRAMBLE = 15'h0203;
    localparam logic [14:0] PMLP_ADDR_DEV_ID = 15'h0204;
    localparam logic [14:0] PMLP_ADDR_ST_LANES = 15'h0208;
    localparam logic [14:0] PMLP_ADDR_ST_CONV = 15'h0209;
    localparam logic [14:0] PMLP_ADDR_ST_OCTETS = 15'h020A;
    localparam logic [14:0] PMLP_ADDR_ST_SAMPLES = 15'h020B;
    localparam logic [14:0] PMLP_ADDR_ST_RES = 15'h020C;
    localparam logic [14:0] PMLP_ADDR_ST_FLAGS = 15'h020D;
    localparam logic [14:0] PMLP_ADDR_ST_RATIO_LO = 15'h020E;
    localparam logic [14:0] PMLP_ADDR_ST_RATIO_HI = 15'h020F;
    localparam logic [14:0] PMLP_ADDR_ST_KM1 = 15'h0210;
    localparam logic [14:0] PMLP_ADDR_ST_CKSUM0 = 15'h0211;
    localparam logic [14:0] PMLP_ADDR_TRIM_B = 15'h029A;
    localparam logic [14:0] PMLP_ADDR_TRIM_G = 15'h029B;
    localparam logic [14:0] PMLP_ADDR_TRIM_D = 15'h029C;

    // field positions
    localparam int PMLP_BIT_ENABLE = 0;
    localparam int PMLP_FLAG_ENC = 0;
    localparam int PMLP_FLAG_ILLEGAL = 1;

    // reset values: power trims come up at high performance settings
    localparam logic [7:0] PMLP_RST_TRIM_A = 8'h4B;
    localparam logic [7:0] PMLP_RST_TRIM_B = 8'h0F;
    localparam logic [7:0] PMLP_RST_TRIM_G = 8'h04;
    localparam logic [7:0] PMLP_RST_TRIM_D = 8'h1B;
    localparam logic [4:0] PMLP_RST_LINK_MODE = 5'h00;
    localparam logic [7:0] PMLP_RST_FRAME_CNT = 8'h1F;
    localparam logic [7:0] PMLP_RST_DEV_ID = 8'h00;

    // core swap timing in sample clocks
    localparam int PMLP_SWAP_MIN_CYC = 500;
    localparam int PMLP_SWAP_MAX_CYC = 1000;
    localparam int PMLP_SWAP_DELAY_CYC = 750;
    localparam int PMLP_BG_SWAP_PERIOD_CYC = 2048;

    // constant alignment sequence fields
    localparam logic [7:0] PMLP_ILAS_JESDV = 8'h01;
    localparam logic [7:0] PMLP_ILAS_SUBCLASSV = 8'h01;
    localparam logic [9:0] PMLP_K64_NUM = 10'h100;
    localparam logic [1:0] PMLP_E64 = 2'h1;
    localparam int PMLP_LANES = 8;

    // serial port frame: r/w bit, 15 address bits, 8 data bits
    localparam logic [4:0] PMLP_SPI_HDR_BITS = 5'h10;
    localparam logic [4:0] PMLP_SPI_FRAME_BITS = 5'h18;

    typedef enum logic [1:0] {
        PMLP_CAL_FG = 2'b00,
        PMLP_CAL_BG = 2'b01,
        PMLP_CAL_LPBG = 2'b10
    } pmlp_cal_mode_e;

endpackage

// ### logic/pmlp_mode_rom.sv
`timescale 1ns/1ns
module pmlp_mode_rom
    import pmlp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] mode,
    output logic enc64,
    output logic [3:0] res_n,
    output logic [3:0] lanes,
    output logic [3:0] conv_m,
    output logic [3:0] octets_f,
    output logic [2:0] samples_s,
    output logic [9:0] ratio_x32,
    output logic illegal
);
    typedef struct packed {
        logic enc64;
        logic [3:0] n;
        logic [3:0] l;
        logic [3:0] m;
        logic [3:0] f;
        logic [2:0] s;
        logic [9:0] rx32;
        logic illegal;
    } pmlp_rom_s;

    pmlp_rom_s q, d;

    // mode table lookup, ratio held with five fraction bits
    always_comb begin
        unique case (mode)
            5'h00: d = {1'b0, 4'hC, 4'h8, 4'h8, 4'h8, 3'h5, 10'h100, 1'b0};
            5'h01: d = {1'b0, 4'hC, 4'h6, 4'h4, 4'h2, 3'h2, 10'h140, 1'b0};
            5'h02: d = {1'b0, 4'h8, 4'h4, 4'h4, 4'h1, 3'h1, 10'h140, 1'b0};
            5'h03: d = {1'b0, 4'hA, 4'h4, 4'h4, 4'h5, 3'h4, 10'h190, 1'b0};
            5'h04: d = {1'b1, 4'hC, 4'h3, 4'h4, 4'h2, 3'h1, 10'h210, 1'b0};
            5'h05: d = {1'b1, 4'h8, 4'h2, 4'h4, 4'h2, 3'h1, 10'h210, 1'b0};
            5'h06: d = {1'b1, 4'hC, 4'h6, 4'h4, 4'h2, 3'h2, 10'h108, 1'b0};
            5'h07: d = {1'b1, 4'h8, 4'h4, 4'h4, 4'h1, 3'h1, 10'h108, 1'b0};
            5'h08: d = {1'b1, 4'hC, 4'h4, 4'h4, 4'h3, 3'h2, 10'h18C, 1'b0};
            5'h09: d = {1'b0, 4'h8, 4'h8, 4'h4, 4'h1, 3'h2, 10'h0A0, 1'b0};
            5'h0A: d = {1'b0, 4'hA, 4'h8, 4'h8, 4'h5, 3'h4, 10'h0C8, 1'b0};
            5'h0B: d = {1'b0, 4'hC, 4'h8, 4'h8, 4'h8, 3'h5, 10'h080, 1'b0};
            5'h0C: d = {1'b0, 4'h8, 4'h8, 4'h2, 4'h1, 3'h4, 10'h050, 1'b0};
            5'h0D: d = {1'b0, 4'hA, 4'h8, 4'h8, 4'h5, 3'h4, 10'h064, 1'b0};
            5'h0E: d = {1'b1, 4'hC, 4'h8, 4'h8, 4'h3, 3'h2, 10'h0C6, 1'b0};
            5'h0F: d = {1'b1, 4'hC, 4'h8, 4'h8, 4'h3, 3'h2, 10'h063, 1'b0};
            default: d = {1'b0, 4'h0, 4'h0, 4'h0, 4'h0, 3'h0, 10'h000, 1'b1};
        endcase
    end

    // registered read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign enc64 = q.enc64;
    assign res_n = q.n;
    assign lanes = q.l;
    assign conv_m = q.m;
    assign octets_f = q.f;
    assign samples_s = q.s;
    assign ratio_x32 = q.rx32;
    assign illegal = q.illegal;
endmodule

// ### logic/pmlp_spi_port.sv
`timescale 1ns/1ns
module pmlp_spi_port
    import pmlp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scs_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    output logic wr_stb,
    output logic [14:0] addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    typedef struct packed {
        logic sclk_prev;
        logic [4:0] cnt;
        logic [23:0] sh;
        logic rd;
        logic [7:0] out_sh;
        logic oe_n;
        logic wr_stb;
        logic [14:0] addr;
        logic [7:0] wr_data;
    } pmlp_spi_s;

    pmlp_spi_s q, d;

    // sample on rising sclk, shift read data out on falling sclk
    always_comb begin
        d = q;
        d.sclk_prev = sclk;
        d.wr_stb = 1'b0;
        if (scs_n) begin
            d.cnt = 5'h00;
            d.oe_n = 1'b1;
            d.rd = 1'b0;
        end else if (sclk && !q.sclk_prev) begin
            d.sh = {q.sh[22:0], sdi};
            d.cnt = q.cnt + 5'h01;
            if (d.cnt == PMLP_SPI_HDR_BITS) begin
                d.addr = d.sh[14:0];
                d.rd = d.sh[15];
            end
            if (d.cnt == PMLP_SPI_FRAME_BITS && !q.rd) begin
                d.wr_data = d.sh[7:0];
                d.wr_stb = 1'b1;
            end
        end else if (!sclk && q.sclk_prev && q.rd) begin
            if (q.cnt == PMLP_SPI_HDR_BITS) begin
                d.out_sh = rd_data;
                d.oe_n = 1'b0;
            end else begin
                d.out_sh = {q.out_sh[6:0], 1'b0};
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{oe_n: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign sdo = q.out_sh[7];
    assign sdo_oe_n = q.oe_n;
    assign wr_stb = q.wr_stb;
    assign addr = q.addr;
    assign wr_data = q.wr_data;
endmodule

// ### logic/pmlp_power_link.sv
`timescale 1ns/1ns
module pmlp_power_link
    import pmlp_pkg::*;
#(
    parameter int SWAP_DELAY_CYC = PMLP_SWAP_DELAY_CYC,
    parameter int BG_SWAP_PERIOD_CYC = PMLP_BG_SWAP_PERIOD_CYC
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic SCS_N,
    input wire logic SCLK,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE_N,
    input wire logic CALIBRATION_TRIGGER_PIN,
    output logic [7:0] POWER_TRIM_A,
    output logic [7:0] POWER_TRIM_B,
    output logic [7:0] POWER_TRIM_GLITCH,
    output logic [7:0] POWER_TRIM_D,
    output logic CAL_ENABLE,
    output logic CORE_SWAP,
    output logic LINK_RESET_N,
    output logic SERDES_PD,
    output logic LINK_CLK_EN,
    output logic [7:0] LANE_PD,
    output logic LINK_MODE_ILLEGAL,
    output logic ENC_64B66B,
    output logic [3:0] LANES,
    output logic [3:0] CONVERTERS,
    output logic [3:0] OCTETS_PER_FRAME,
    output logic [2:0] SAMPLES_PER_FRAME,
    output logic [3:0] RESOLUTION,
    output logic [9:0] RATIO_X32,
    output logic [8:0] FRAMES_PER_MF,
    output logic [1:0] MB_PER_EMB,
    output logic [7:0] DEVICE_ID,
    output logic SCRAMBLER_EN,
    output logic [63:0] ILAS_CHECKSUM
);
    localparam logic [9:0] SWAP_LAST = 10'(SWAP_DELAY_CYC - 1);
    localparam int BG_W = $clog2(BG_SWAP_PERIOD_CYC);
    localparam logic [BG_W-1:0] BG_LAST = BG_W'(BG_SWAP_PERIOD_CYC - 1);

    typedef struct packed {
        logic [7:0] trim_a;
        logic [7:0] trim_b;
        logic [7:0] trim_g;
        logic [7:0] trim_d;
        logic cal_en;
        logic [1:0] cal_mode;
        logic lowpower_swap_trigger_control;
        logic link_en;
        logic [4:0] mode;
        logic [7:0] frame_cnt;
        logic scrambler_enable;
        logic [7:0] dev_id;
        logic [7:0] rd_data;
        logic pin_prev;
        logic swap_run;
        logic [9:0] swap_cnt;
        logic [BG_W-1:0] bg_cnt;
        logic core_swap;
        logic link_rst_n;
        logic serdes_pd;
        logic clk_en;
        logic [7:0] lane_pd;
        logic illegal;
        logic enc64;
        logic [3:0] l;
        logic [3:0] m;
        logic [3:0] f;
        logic [2:0] s;
        logic [3:0] n;
        logic [9:0] rx32;
        logic [8:0] k;
        logic [1:0] e;
        logic [7:0] did;
        logic scr_o;
        logic [63:0] cksum;
    } pmlp_state_s;

    pmlp_state_s q, d;

    logic wr_stb;
    logic [14:0] addr;
    logic [7:0] wr_data;
    logic rom_enc64;
    logic [3:0] rom_n;
    logic [3:0] rom_l;
    logic [3:0] rom_m;
    logic [3:0] rom_f;
    logic [2:0] rom_s;
    logic [9:0] rom_rx32;
    logic rom_illegal;

    // field values minus one as carried in the alignment octets
    function automatic logic [7:0] pmlp_m1(input logic [8:0] v);
        logic [8:0] t;
        t = v - 9'h001;
        return t[7:0];
    endfunction

    // sum of all alignment fields except lane id, modulo 256
    function automatic logic [7:0] pmlp_ilas_sum(
        input logic [7:0] did, input logic [3:0] l, input logic scrambler_enable, input logic [3:0] f,
        input logic [8:0] k, input logic [3:0] m, input logic [3:0] n, input logic [2:0] s
    );
        logic [7:0] sum;
        sum = did + pmlp_m1({5'h00, l}) + {7'h00, scrambler_enable} + pmlp_m1({5'h00, f}) + pmlp_m1(k);
        sum = sum + pmlp_m1({5'h00, m}) + pmlp_m1({5'h00, n}) + pmlp_m1({5'h00, n});
        sum = sum + PMLP_ILAS_SUBCLASSV + PMLP_ILAS_JESDV + pmlp_m1({6'h00, s});
        return sum;
    endfunction

    pmlp_spi_port u_spi (
        .clk(CLOCK),
        .rst_n(RST_N),
        .scs_n(SCS_N),
        .sclk(SCLK),
        .sdi(SDI),
        .sdo(SDO),
        .sdo_oe_n(SDO_OE_N),
        .wr_stb(wr_stb),
        .addr(addr),
        .wr_data(wr_data),
        .rd_data(q.rd_data)
    );

    pmlp_mode_rom u_rom (
        .clk(CLOCK),
        .rst_n(RST_N),
        .mode(q.mode),
        .enc64(rom_enc64),
        .res_n(rom_n),
        .lanes(rom_l),
        .conv_m(rom_m),
        .octets_f(rom_f),
        .samples_s(rom_s),
        .ratio_x32(rom_rx32),
        .illegal(rom_illegal)
    );

    // register writes, swap timing and link parameter derivation
    always_comb begin
        logic trig;
        logic [8:0] k_new;
        logic [7:0] base;
        trig = 1'b0;
        k_new = 9'h000;
        base = 8'h00;
        d = q;
        d.pin_prev = CALIBRATION_TRIGGER_PIN;
        d.core_swap = 1'b0;

        // register writes from the serial port
        if (wr_stb) begin
            unique case (addr)
                PMLP_ADDR_TRIM_A: d.trim_a = wr_data;
                PMLP_ADDR_TRIM_B: d.trim_b = wr_data;
                PMLP_ADDR_TRIM_G: d.trim_g = wr_data;
                PMLP_ADDR_TRIM_D: d.trim_d = wr_data;
                PMLP_ADDR_CAL_EN: d.cal_en = wr_data[PMLP_BIT_ENABLE];
                PMLP_ADDR_CAL_MODE: d.cal_mode = wr_data[1:0];
                PMLP_ADDR_SOFT_TRIG: trig = wr_data[PMLP_BIT_ENABLE];
                PMLP_ADDR_LOWPOWER_SWAP_TRIGGER_CONTROL: d.lowpower_swap_trigger_control = wr_data[PMLP_BIT_ENABLE];
                PMLP_ADDR_LINK_EN: d.link_en = wr_data[PMLP_BIT_ENABLE];
                PMLP_ADDR_LINK_MODE: d.mode = wr_data[4:0];
                PMLP_ADDR_FRAME_CNT: d.frame_cnt = wr_data;
                PMLP_ADDR_SCRAMBLE: d.scrambler_enable = wr_data[PMLP_BIT_ENABLE];
                PMLP_ADDR_DEV_ID: d.dev_id = wr_data;
                default: ;
            endcase
        end

        // pin rising edge or soft write starts swap
        if (CALIBRATION_TRIGGER_PIN && !q.pin_prev) begin
            trig = 1'b1;
        end

        if (!q.cal_en || (q.cal_mode != PMLP_CAL_BG && q.cal_mode != PMLP_CAL_LPBG)) begin
            d.swap_run = 1'b0;
            d.swap_cnt = 10'h000;
            d.bg_cnt = '0;
        end else if (q.cal_mode == PMLP_CAL_LPBG && q.lowpower_swap_trigger_control) begin
            if (q.swap_run) begin
                d.swap_cnt = q.swap_cnt + 10'h001;
                if (q.swap_cnt == SWAP_LAST) begin
                    d.core_swap = 1'b1;
                    d.swap_run = 1'b0;
                end
            end else if (trig) begin
                d.swap_run = 1'b1;
                d.swap_cnt = 10'h000;
            end
        end else begin
            // free-running background swaps
            d.swap_run = 1'b0;
            d.bg_cnt = q.bg_cnt + 1'b1;
            if (q.bg_cnt == BG_LAST) begin
                d.bg_cnt = '0;
                d.core_swap = 1'b1;
            end
        end

        // link held in reset, powered down, clock gated while disabled
        d.link_rst_n = q.link_en;
        d.serdes_pd = !q.link_en;
        d.clk_en = q.link_en;

        // parameters track registers only while disabled
        if (!q.link_en) begin
            d.illegal = rom_illegal;
            d.enc64 = rom_enc64;
            d.l = rom_l;
            d.m = rom_m;
            d.f = rom_f;
            d.s = rom_s;
            d.n = rom_n;
            // ratio drives line rate and pll factor
            d.rx32 = rom_rx32;
            if (rom_enc64) begin
                k_new = (rom_f == 4'h0) ? 9'h000 : 9'((PMLP_K64_NUM * PMLP_E64) / rom_f);
                d.e = PMLP_E64;
            end else begin
                k_new = {1'b0, q.frame_cnt} + 9'h001;
                d.e = 2'h0;
            end
            d.k = k_new;
            // device id and scrambler from registers
            d.did = q.dev_id;
            d.scr_o = q.scrambler_enable;
            // zero and one fields folded in
            base = pmlp_ilas_sum(q.dev_id, rom_l, q.scrambler_enable, rom_f, k_new, rom_m, rom_n, rom_s);
            for (int i = 0; i < PMLP_LANES; i++) begin
                // lane id is the lane index
                d.cksum[i*8 +: 8] = base + 8'(i);
            end
        end

        // unused lanes powered down, all when disabled
        for (int i = 0; i < PMLP_LANES; i++) begin
            d.lane_pd[i] = !q.link_en || (4'(i) >= q.l);
        end

        // read data for the serial port
        unique case (addr)
            PMLP_ADDR_TRIM_A: d.rd_data = q.trim_a;
            PMLP_ADDR_TRIM_B: d.rd_data = q.trim_b;
            PMLP_ADDR_TRIM_G: d.rd_data = q.trim_g;
            PMLP_ADDR_TRIM_D: d.rd_data = q.trim_d;
            PMLP_ADDR_CAL_EN: d.rd_data = {7'h00, q.cal_en};
            PMLP_ADDR_CAL_MODE: d.rd_data = {6'h00, q.cal_mode};
            PMLP_ADDR_LOWPOWER_SWAP_TRIGGER_CONTROL: d.rd_data = {7'h00, q.lowpower_swap_trigger_control};
            PMLP_ADDR_LINK_EN: d.rd_data = {7'h00, q.link_en};
            PMLP_ADDR_LINK_MODE: d.rd_data = {3'h0, q.mode};
            PMLP_ADDR_FRAME_CNT: d.rd_data = q.frame_cnt;
            PMLP_ADDR_SCRAMBLE: d.rd_data = {7'h00, q.scrambler_enable};
            PMLP_ADDR_DEV_ID: d.rd_data = q.dev_id;
            PMLP_ADDR_ST_LANES: d.rd_data = {4'h0, q.l};
            PMLP_ADDR_ST_CONV: d.rd_data = {4'h0, q.m};
            PMLP_ADDR_ST_OCTETS: d.rd_data = {4'h0, q.f};
            PMLP_ADDR_ST_SAMPLES: d.rd_data = {5'h00, q.s};
            PMLP_ADDR_ST_RES: d.rd_data = {4'h0, q.n};
            PMLP_ADDR_ST_FLAGS: d.rd_data = {4'h0, q.e, q.illegal, q.enc64};
            PMLP_ADDR_ST_RATIO_LO: d.rd_data = q.rx32[7:0];
            PMLP_ADDR_ST_RATIO_HI: d.rd_data = {6'h00, q.rx32[9:8]};
            PMLP_ADDR_ST_KM1: d.rd_data = pmlp_m1(q.k);
            PMLP_ADDR_ST_CKSUM0: d.rd_data = q.cksum[7:0];
            default: d.rd_data = 8'h00;
        endcase
    end

    // state register; trims reset to high performance values
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '{trim_a: PMLP_RST_TRIM_A, trim_b: PMLP_RST_TRIM_B, trim_g: PMLP_RST_TRIM_G,
                   trim_d: PMLP_RST_TRIM_D, mode: PMLP_RST_LINK_MODE, frame_cnt: PMLP_RST_FRAME_CNT,
                   dev_id: PMLP_RST_DEV_ID, serdes_pd: 1'b1, lane_pd: 8'hFF, default: '0};
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign POWER_TRIM_A = q.trim_a;
    assign POWER_TRIM_B = q.trim_b;
    assign POWER_TRIM_GLITCH = q.trim_g;
    assign POWER_TRIM_D = q.trim_d;
    assign CAL_ENABLE = q.cal_en;
    assign CORE_SWAP = q.core_swap;
    assign LINK_RESET_N = q.link_rst_n;
    assign SERDES_PD = q.serdes_pd;
    assign LINK_CLK_EN = q.clk_en;
    assign LANE_PD = q.lane_pd;
    assign LINK_MODE_ILLEGAL = q.illegal;
    assign ENC_64B66B = q.enc64;
    assign LANES = q.l;
    assign CONVERTERS = q.m;
    assign OCTETS_PER_FRAME = q.f;
    assign SAMPLES_PER_FRAME = q.s;
    assign RESOLUTION = q.n;
    assign RATIO_X32 = q.rx32;
    assign FRAMES_PER_MF = q.k;
    assign MB_PER_EMB = q.e;
    assign DEVICE_ID = q.did;
    assign SCRAMBLER_EN = q.scr_o;
    assign ILAS_CHECKSUM = q.cksum;
endmodule

// ### tb/pmlp_power_link_assertions.sv
`timescale 1ns/1ns
module pmlp_power_link_assertions (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [7:0] POWER_TRIM_A,
    input wire logic [7:0] POWER_TRIM_D,
    input wire logic CAL_ENABLE,
    input wire logic CORE_SWAP,
    input wire logic LINK_RESET_N,
    input wire logic SERDES_PD,
    input wire logic LINK_CLK_EN,
    input wire logic [7:0] LANE_PD,
    input wire logic ENC_64B66B,
    input wire logic [3:0] LANES,
    input wire logic [3:0] OCTETS_PER_FRAME,
    input wire logic [9:0] RATIO_X32,
    input wire logic [8:0] FRAMES_PER_MF,
    input wire logic [1:0] MB_PER_EMB,
    input wire logic [63:0] ILAS_CHECKSUM
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // power trims and link block state
    trim_reset_a: assert property ($rose(RST_N) |-> POWER_TRIM_A == 8'h4B && POWER_TRIM_D == 8'h1B)
        else $error("trims not at high performance after reset");
    link_off_a: assert property (!LINK_RESET_N |-> SERDES_PD && !LINK_CLK_EN && LANE_PD == 8'hFF)
        else $error("link held in reset but not powered down");
    lane_pd_a: assert property (LINK_RESET_N |-> LANE_PD == 8'(8'hFF << LANES))
        else $error("unused lanes not powered down");
    // derived parameters, frozen while link runs; no core swap with calibration off
    param_hold_a: assert property (LINK_RESET_N && $past(LINK_RESET_N) |->
        $stable(LANES) && $stable(RATIO_X32) && $stable(ILAS_CHECKSUM)) else $error("parameters moved while enabled");
    ext_mb_a: assert property (MB_PER_EMB == (ENC_64B66B ? 2'h1 : 2'h0))
        else $error("extended multiblock count wrong");
    k_64b_a: assert property (ENC_64B66B && OCTETS_PER_FRAME != 4'h0 |->
        FRAMES_PER_MF == 9'(10'h100 / OCTETS_PER_FRAME)) else $error("64b66b frame count wrong");
    checksum_lane_a: assert property (LANES != 4'h0 |-> ILAS_CHECKSUM[15:8] == ILAS_CHECKSUM[7:0] + 8'h01
        && ILAS_CHECKSUM[63:56] == ILAS_CHECKSUM[7:0] + 8'h07) else $error("lane checksums not offset by lane");
    cal_off_a: assert property (!CAL_ENABLE && !$past(CAL_ENABLE) |-> !CORE_SWAP)
        else $error("core swap with calibration off");
endmodule
bind pmlp_power_link pmlp_power_link_assertions chk_i (.CLOCK(CLOCK), .RST_N(RST_N), .POWER_TRIM_A(POWER_TRIM_A),
    .POWER_TRIM_D(POWER_TRIM_D), .CAL_ENABLE(CAL_ENABLE), .CORE_SWAP(CORE_SWAP), .LINK_RESET_N(LINK_RESET_N),
    .SERDES_PD(SERDES_PD), .LINK_CLK_EN(LINK_CLK_EN), .LANE_PD(LANE_PD), .ENC_64B66B(ENC_64B66B), .LANES(LANES),
    .OCTETS_PER_FRAME(OCTETS_PER_FRAME), .RATIO_X32(RATIO_X32), .FRAMES_PER_MF(FRAMES_PER_MF),
    .MB_PER_EMB(MB_PER_EMB), .ILAS_CHECKSUM(ILAS_CHECKSUM));

// ### tb/pmlp_spi_host.sv
`timescale 1ns/1ns
module pmlp_spi_host (
    input wire logic clk,
    input wire logic sdo,
    output logic scs_n,
    output logic sclk,
    output logic sdi
);
    // idle: deselected, clock parked low
    initial begin
        scs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // one frame of 24 bits, msb first; read data sampled on each rise
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [23:0] fr;
        fr = {rd, a, wd};
        q = 8'h00;
        @(posedge clk) scs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk) sdi <= fr[i];
            repeat (3) @(posedge clk);
            sclk <= 1'b1;
            q = {q[6:0], sdo};
            repeat (3) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (3) @(posedge clk);
        scs_n <= 1'b1;
        sdi <= ~sdi; // released line does not keep its last bit
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
endmodule

// ### tb/pmlp_power_link_test.sv
`timescale 1ns/1ns
module pmlp_power_link_test;
    import pmlp_pkg::*;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic trig_pin = 1'b0;
    logic scs_n, sclk, sdi, sdo, swap, lrn, spd, lce, ill, enc, oen, cal, scrambler_enable;
    wire logic [3:0][7:0] tr;
    logic [7:0] lpd, dvid;
    logic [3:0] l, m, f, n;
    logic [2:0] s;
    logic [9:0] rat;
    logic [8:0] k;
    logic [1:0] e;
    logic [63:0] ck;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    wire logic [41:0] der = {enc, l, m, f, s, n, rat, k, e, ill};
    wire logic [10:0] lnk = {lrn, spd, lce, lpd};
    // undriven sdo line shows the inverse of the stale bit
    wire logic sdo_w = oen ? ~sdo : sdo;
    localparam logic [41:0] mode0_exp = {1'b0, 4'h8, 4'h8, 4'h8, 3'h5, 4'hC, 10'h100, 9'h004, 2'h0, 1'b0};
    localparam logic [41:0] mode15_exp = {1'b1, 4'h8, 4'h8, 4'h3, 3'h2, 4'hC, 10'h063, 9'h055, 2'h1, 1'b0};
    localparam logic [41:0] mode7_exp = {1'b1, 4'h4, 4'h4, 4'h1, 3'h1, 4'h8, 10'h108, 9'h100, 2'h1, 1'b0};
    // sample clock is the 20 MHz device clock, far below the low power rate limit
    always #25 CLOCK = ~CLOCK;
    pmlp_spi_host host (.clk(CLOCK), .sdo(sdo_w), .scs_n(scs_n), .sclk(sclk), .sdi(sdi));
    pmlp_power_link #(.SWAP_DELAY_CYC(PMLP_SWAP_DELAY_CYC), .BG_SWAP_PERIOD_CYC(16)) uut (.CLOCK(CLOCK),
        .RST_N(RST_N), .SCS_N(scs_n), .SCLK(sclk), .SDI(sdi), .SDO(sdo), .SDO_OE_N(oen),
        .CALIBRATION_TRIGGER_PIN(trig_pin),
        .POWER_TRIM_A(tr[3]), .POWER_TRIM_B(tr[2]), .POWER_TRIM_GLITCH(tr[1]), .POWER_TRIM_D(tr[0]),
        .CAL_ENABLE(cal), .CORE_SWAP(swap), .LINK_RESET_N(lrn), .SERDES_PD(spd), .LINK_CLK_EN(lce), .LANE_PD(lpd),
        .LINK_MODE_ILLEGAL(ill), .ENC_64B66B(enc), .LANES(l), .CONVERTERS(m), .OCTETS_PER_FRAME(f),
        .SAMPLES_PER_FRAME(s), .RESOLUTION(n), .RATIO_X32(rat), .FRAMES_PER_MF(k), .MB_PER_EMB(e),
        .DEVICE_ID(dvid), .SCRAMBLER_EN(scrambler_enable), .ILAS_CHECKSUM(ck));
    // comparison and register access helpers
    task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
        num_checks++;
        if (got !== ex) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(1'b0, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [14:0] a, input logic [7:0] ex);
        logic [7:0] q;
        host.xfer(1'b1, a, 8'h00, q);
        chk(nm, 64'(ex), 64'(q));
    endtask
    task automatic set_trims(input logic [31:0] v);
        wr(PMLP_ADDR_TRIM_A, v[31:24]);
        wr(PMLP_ADDR_TRIM_B, v[23:16]);
        wr(PMLP_ADDR_TRIM_G, v[15:8]);
        wr(PMLP_ADDR_TRIM_D, v[7:0]);
    endtask
    task automatic wait_swap(output int cnt);
        cnt = 0;
        while (swap !== 1'b1 && cnt < 1100) begin
            @(negedge CLOCK);
            cnt++;
        end
    endtask
    // scenarios
    task automatic t_reset();
        chk("trims", 64'h4B0F041B, 64'(tr));
        chk("link idle", 64'h2FF, 64'(lnk));
        chk("sdo idle", 64'h1, 64'(oen));
        rdc("trim a", PMLP_ADDR_TRIM_A, 8'h4B);
        rdc("unmapped", 15'h7FFF, 8'h00);
        rdc("soft trig", PMLP_ADDR_SOFT_TRIG, 8'h00);
    endtask
    task automatic t_power();
        set_trims(32'h46060014);
        chk("low power", 64'h46060014, 64'(tr));
        rdc("glitch trim", PMLP_ADDR_TRIM_G, 8'h00);
        set_trims(32'h4B0F041B);
        chk("high perf", 64'h4B0F041B, 64'(tr));
    endtask
    task automatic t_modes();
        wr(PMLP_ADDR_FRAME_CNT, 8'h03);
        wr(PMLP_ADDR_DEV_ID, 8'h10);
        wr(PMLP_ADDR_SCRAMBLE, 8'h01);
        wr(PMLP_ADDR_LINK_MODE, 8'h00);
        repeat (4) @(negedge CLOCK);
        chk("mode 0", 64'(mode0_exp), 64'(der));
        chk("device id", 64'h10, 64'(dvid));
        chk("scrambler", 64'h1, 64'(scrambler_enable));
        chk("checksums", 64'h4C4B4A4948474645, ck);
        rdc("lane 0 checksum", PMLP_ADDR_ST_CKSUM0, 8'h45);
        wr(PMLP_ADDR_LINK_MODE, 8'h0F);
        repeat (4) @(negedge CLOCK);
        chk("mode 15", 64'(mode15_exp), 64'(der));
        wr(PMLP_ADDR_LINK_MODE, 8'h10);
        repeat (4) @(negedge CLOCK);
        chk("illegal mode", 64'h1, 64'(ill));
        wr(PMLP_ADDR_LINK_MODE, 8'h07);
        repeat (4) @(negedge CLOCK);
        chk("mode 7", 64'(mode7_exp), 64'(der));
    endtask
    task automatic t_link();
        wr(PMLP_ADDR_LINK_EN, 8'h01);
        chk("link on", 64'h5F0, 64'(lnk));
        wr(PMLP_ADDR_LINK_MODE, 8'h00);
        repeat (4) @(negedge CLOCK);
        chk("held", 64'(mode7_exp), 64'(der));
        wr(PMLP_ADDR_LINK_EN, 8'h00);
        chk("link off", 64'h2FF, 64'(lnk));
        repeat (4) @(negedge CLOCK);
        chk("released", 64'(mode0_exp), 64'(der));
    endtask
    task automatic t_swap();
        int cnt;
        wr(PMLP_ADDR_CAL_MODE, 8'h02);
        wr(PMLP_ADDR_LOWPOWER_SWAP_TRIGGER_CONTROL, 8'h01);
        wr(PMLP_ADDR_CAL_EN, 8'h01);
        chk("cal enable", 64'h1, 64'(cal));
        @(posedge CLOCK) trig_pin <= 1'b1;
        @(posedge CLOCK) trig_pin <= 1'b0;
        wait_swap(cnt);
        chk("pin swap delay", 64'h1, 64'(cnt >= PMLP_SWAP_MIN_CYC && cnt <= PMLP_SWAP_MAX_CYC));
        wr(PMLP_ADDR_SOFT_TRIG, 8'h01);
        wait_swap(cnt);
        chk("soft swap delay", 64'h1, 64'(cnt >= PMLP_SWAP_MIN_CYC && cnt <= PMLP_SWAP_MAX_CYC));
        wr(PMLP_ADDR_CAL_MODE, 8'h01);
        wait_swap(cnt);
        chk("bg swap", 64'h1, 64'(cnt <= 16));
        wr(PMLP_ADDR_CAL_MODE, 8'h00);
        wait_swap(cnt);
        chk("foreground swap", 64'd1100, 64'(cnt));
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        repeat (4) @(negedge CLOCK);
        t_reset();
        t_power();
        t_modes();
        t_link();
        t_swap();
        finish_test();
    end
endmodule
